// file: src/cpw_cfg.svh
// constants for the code memory panel writer
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH
`define CPW_PANELS          4
`define CPW_BUF_BYTES       8
`define CPW_PTR_W           22
`define CPW_CMD_CORE        4'h0
`define CPW_CMD_WRITE       4'hc
`define CPW_CMD_WRITE_INC   4'hd
`define CPW_CMD_START       4'hf
`define CPW_PROG_CTRL_ADDR  22'h3c_0006
`define CPW_PROG_CTRL_RST   8'h00
`define CPW_MULTI_BIT       6
`define CPW_MULTI_VALUE     8'h40
`define CPW_PTR_STEP        22'h00_0002
`define CPW_PANEL_LSB       13
`define CPW_PANEL_SIZE      22'h00_2000
`define CPW_HOLD_EDGE       2'h3
`endif

// file: src/cpw_pkg.sv
// types shared by the code memory panel writer
package cpw_pkg;
    typedef struct packed {
        logic [3:0]  code;
        logic [15:0] payload;
    } cpw_cmd_s;

    typedef struct packed {
        logic         active;
        logic         multi;
        logic [3:0]   panel_en;
        logic [12:0]  offset;
        logic [255:0] data;
    } cpw_prog_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_PROG  = 3'b100
    } cpw_state_e;
endpackage

// file: src/cpw_edge_sync.sv
// serial clock synchroniser with edge detection
`timescale 1ns/100ps
module cpw_edge_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // pin side
    input  wire logic sclk_pin,
    // core side
    output logic      sclk_level,
    output logic      sclk_rise,
    output logic      sclk_fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= sclk_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign sclk_level = sync_q;
    assign sclk_rise  = sync_q & ~last_q;
    assign sclk_fall  = ~sync_q & last_q;
endmodule // cpw_edge_sync

// file: src/cpw_panel_writer.sv
// code memory panel write buffers and externally timed programming sequencer
// Behaviour
// - each of the four panels owns an eight-byte write buffer that is loaded before a write starts.
// - a write sequence programs each enabled panel from its own buffer contents.
// - in multi-panel mode all panels are programmed at once at the same in-panel offset.
// - writing 40h to the programming control register at 3C0006h turns multi-panel mode on.
// - no internal timer: command 1111 stores its two bytes and starts programming.
// - programming ends when the serial clock falls; the programmer then holds it low for the discharge time.
// - command 1101 stores two bytes low first at the pointer and adds 2; command 1100 stores without advancing.
// - with multi-panel mode off only the panel picked by the table pointer is enabled.
// - code memory needs code space select set and config space select clear in the nvm control register.
`timescale 1ns/100ps
`include "cpw_cfg.svh"
module cpw_panel_writer (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // serial clock pin
    input  wire logic              sclk_pin,
    // decoded serial commands
    input  wire logic              cmd_valid,
    input  wire cpw_pkg::cpw_cmd_s cmd,
    // table pointer load from the core
    input  wire logic              ptr_load,
    input  wire logic [21:0]       ptr_value,
    // nvm control one bits from the core
    input  wire logic              code_space_select,
    input  wire logic              config_space_select,
    input  wire logic              write_enable_bit,
    // status
    output logic [21:0]            table_pointer,
    output logic [7:0]             programming_control,
    output logic [3:0]             buffer_full,
    // to the code memory array
    output cpw_pkg::cpw_prog_s     prog
);
    import cpw_pkg::*;

    function automatic logic [3:0] panel_onehot(input logic [1:0] idx);
        panel_onehot = 4'h1 << idx;
    endfunction

    logic       sclk_level;
    logic       sclk_rise;
    logic       sclk_fall;

    cpw_edge_sync u_sync (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .sclk_pin   (sclk_pin),
        .sclk_level (sclk_level),
        .sclk_rise  (sclk_rise),
        .sclk_fall  (sclk_fall)
    );

    cpw_state_e  state_q, state_d;
    logic [1:0]  edges_q, edges_d;
    logic [21:0] ptr_q, ptr_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  buf_q [`CPW_PANELS][`CPW_BUF_BYTES];
    logic [7:0]  buf_d [`CPW_PANELS][`CPW_BUF_BYTES];
    logic [7:0]  mask_q [`CPW_PANELS];
    logic [7:0]  mask_d [`CPW_PANELS];
    logic [3:0]  en_q, en_d;
    logic [12:0] off_q, off_d;
    logic        multi_q, multi_d;

    logic        code_access;
    logic        cfg_access;
    logic        store;
    logic        ctrl_hit;
    logic [1:0]  panel;
    logic [2:0]  byte_idx;
    logic        multi_on;

    assign code_access = code_space_select & ~config_space_select;
    assign cfg_access  = config_space_select;
    assign panel       = ptr_q[`CPW_PANEL_LSB +: 2];
    assign byte_idx    = {ptr_q[2:1], 1'b0};
    assign multi_on    = ctrl_q[`CPW_MULTI_BIT];
    assign store       = cmd_valid && state_q == ST_IDLE &&
                         (cmd.code == `CPW_CMD_WRITE || cmd.code == `CPW_CMD_WRITE_INC ||
                          cmd.code == `CPW_CMD_START);
    assign ctrl_hit    = ptr_q == `CPW_PROG_CTRL_ADDR;

    // pointer, control register and buffers
    always_comb begin
        ptr_d  = ptr_q;
        ctrl_d = ctrl_q;
        buf_d  = buf_q;
        mask_d = mask_q;
        if (ptr_load && state_q == ST_IDLE) begin
            ptr_d = ptr_value;
        end else if (store && cfg_access) begin
            if (ctrl_hit) begin
                ctrl_d = cmd.payload[7:0];
            end
        end else if (store && code_access) begin
            buf_d[panel][byte_idx]        = cmd.payload[7:0];
            buf_d[panel][byte_idx + 3'd1] = cmd.payload[15:8];
            mask_d[panel][byte_idx]        = 1'b1;
            mask_d[panel][byte_idx + 3'd1] = 1'b1;
            if (cmd.code == `CPW_CMD_WRITE_INC) begin
                ptr_d = ptr_q + `CPW_PTR_STEP;
            end
        end
        // every panel's buffer is spent once programming ends, whether or not the array took it
        if (state_q == ST_PROG && sclk_fall) begin
            for (int p = 0; p < `CPW_PANELS; p++) begin
                mask_d[p] = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q  <= '0;
            ctrl_q <= `CPW_PROG_CTRL_RST;
            for (int p = 0; p < `CPW_PANELS; p++) begin
                mask_q[p] <= 8'h00;
                for (int b = 0; b < `CPW_BUF_BYTES; b++) begin
                    buf_q[p][b] <= 8'h00;
                end
            end
        end else begin
            ptr_q  <= ptr_d;
            ctrl_q <= ctrl_d;
            buf_q  <= buf_d;
            mask_q <= mask_d;
        end
    end

    // sequencer: the programmer's serial clock is the only timer
    always_comb begin
        state_d = state_q;
        edges_d = edges_q;
        en_d    = en_q;
        off_d   = off_q;
        multi_d = multi_q;
        unique case (state_q)
            ST_IDLE: begin
                edges_d = 2'h0;
                if (store && code_access && write_enable_bit && cmd.code == `CPW_CMD_START) begin
                    state_d = ST_ARMED;
                    off_d   = {ptr_q[12:3], 3'b000};
                    multi_d = multi_on;
                    en_d    = multi_on ? 4'hf : panel_onehot(panel);
                end
            end
            ST_ARMED: begin
                if (sclk_rise) begin
                    edges_d = edges_q + 2'h1;
                    if (edges_q == `CPW_HOLD_EDGE) begin
                        state_d = ST_PROG;
                    end
                end
            end
            ST_PROG: begin
                if (sclk_fall) begin
                    state_d = ST_IDLE;
                    en_d    = 4'h0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            edges_q <= 2'h0;
            en_q    <= 4'h0;
            off_q   <= 13'h0000;
            multi_q <= 1'b0;
        end else begin
            state_q <= state_d;
            edges_q <= edges_d;
            en_q    <= en_d;
            off_q   <= off_d;
            multi_q <= multi_d;
        end
    end

    // outputs
    always_comb begin
        prog.active   = state_q == ST_PROG;
        prog.multi    = multi_q;
        prog.panel_en = state_q == ST_PROG ? en_q : 4'h0;
        prog.offset   = off_q;
        for (int p = 0; p < `CPW_PANELS; p++) begin
            for (int b = 0; b < `CPW_BUF_BYTES; b++) begin
                prog.data[p*64 + b*8 +: 8] = buf_q[p][b];
            end
        end
    end

    assign table_pointer       = ptr_q;
    assign programming_control = ctrl_q;
    always_comb begin
        for (int p = 0; p < `CPW_PANELS; p++) begin
            buffer_full[p] = &mask_q[p];
        end
    end

    a_start_arms: assert property (@(posedge core_clk) disable iff (!reset_n)
        store && code_access && write_enable_bit && cmd.code == `CPW_CMD_START |=> state_q == ST_ARMED)
        else $error("start command did not arm programming");

    a_fourth_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_ARMED && sclk_rise && edges_q == 2'h3 |=> prog.active)
        else $error("programming not begun on fourth serial clock");

    a_early_edges: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_ARMED && edges_q != 2'h3 |=> !prog.active)
        else $error("programming begun before fourth serial clock");

    a_fall_ends: assert property (@(posedge core_clk) disable iff (!reset_n)
        prog.active && sclk_fall |=> !prog.active && buffer_full == 4'h0)
        else $error("programming not ended on serial clock fall");

    a_ptr_advance: assert property (@(posedge core_clk) disable iff (!reset_n)
        store && code_access && !ptr_load && cmd.code == `CPW_CMD_WRITE_INC
        |=> table_pointer == $past(table_pointer) + 22'h00_0002)
        else $error("pointer did not advance by two");

    a_ptr_stays: assert property (@(posedge core_clk) disable iff (!reset_n)
        store && !ptr_load && cmd.code == `CPW_CMD_WRITE |=> $stable(table_pointer))
        else $error("pointer moved on non-advancing write");

    a_low_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        store && code_access && !ptr_load
        |=> buf_q[$past(panel)][$past(byte_idx)] == $past(cmd.payload[7:0]))
        else $error("low byte not stored at pointer");

    a_ctrl_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        store && cfg_access && ctrl_hit && !ptr_load |=> programming_control == $past(cmd.payload[7:0]))
        else $error("programming control register not written");

    a_multi_all: assert property (@(posedge core_clk) disable iff (!reset_n)
        prog.active && prog.multi |-> prog.panel_en == 4'hf)
        else $error("multi-panel write missing a panel");

    a_single_one: assert property (@(posedge core_clk) disable iff (!reset_n)
        prog.active && !prog.multi |-> $onehot(prog.panel_en))
        else $error("single panel write enabled several panels");

    // programming may only stand while the held clock is still high or just falling
    a_clock_held: assert property (@(posedge core_clk) disable iff (!reset_n)
        prog.active |-> sclk_level || sclk_fall)
        else $error("programming active with serial clock low");

    a_cfg_guard: assert property (@(posedge core_clk) disable iff (!reset_n)
        store && !code_access |=> state_q != ST_ARMED && $stable(buffer_full))
        else $error("code memory touched without code space access");
endmodule // cpw_panel_writer

// file: verif/cpw_programmer_model.sv
// serial clock side of the external programmer
`timescale 1ns/100ps
module cpw_programmer_model #(
    parameter realtime HALF_NS = 62.5,
    parameter realtime PROG_NS = 3000.0,
    parameter realtime DIS_NS  = 1000.0
) (
    // request from the bench
    input  wire logic go,
    // pin side
    output logic      sclk_pin,
    output logic      done
);
    initial begin
        sclk_pin = 1'b0;
        done     = 1'b0;
    end

    // clock stands still low outside a start sequence
    always @(posedge go) begin
        done = 1'b0;
        repeat (3) begin
            #(HALF_NS) sclk_pin = 1'b1;
            #(HALF_NS) sclk_pin = 1'b0;
        end
        #(HALF_NS) sclk_pin = 1'b1;
        #(PROG_NS) sclk_pin = 1'b0;
        #(DIS_NS) done = 1'b1;
    end
endmodule // cpw_programmer_model

// file: verif/code_memory_panel_writer_bench.sv
// self-checking bench for the code memory panel writer
`timescale 1ns/100ps
`include "cpw_cfg.svh"
module code_memory_panel_writer_bench;
    import cpw_pkg::*;
    logic         core_clk, reset_n, cmd_valid, ptr_load, go, done, sclk_pin;
    logic         code_space_select, config_space_select, write_enable_bit;
    logic [21:0]  ptr_value, table_pointer;
    logic [7:0]   programming_control;
    logic [3:0]   buffer_full;
    logic [255:0] exp_data;
    cpw_cmd_s     cmd;
    cpw_prog_s    prog;
    int           num_errors = 0;
    int           num_checks = 0;
    int           cycles = 0;

    cpw_panel_writer u_cpw_panel_writer (.core_clk(core_clk), .reset_n(reset_n), .sclk_pin(sclk_pin),
        .cmd_valid(cmd_valid), .cmd(cmd), .ptr_load(ptr_load), .ptr_value(ptr_value),
        .code_space_select(code_space_select), .config_space_select(config_space_select),
        .write_enable_bit(write_enable_bit), .table_pointer(table_pointer),
        .programming_control(programming_control), .buffer_full(buffer_full), .prog(prog));
    cpw_programmer_model u_cpw_programmer_model (.go(go), .sclk_pin(sclk_pin), .done(done));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic fill(input logic [7:0] key);
        for (int i = 0; i < 32; i++)
            exp_data[i*8 +: 8] = 8'(i) ^ key;
    endtask

    // pointer load then n commands back to back, the last one with its own code
    task automatic load(input logic [21:0] ptr, input logic [63:0] b, input int n, input logic [3:0] last);
        ptr_load  = 1'b1;
        ptr_value = ptr;
        @(posedge core_clk);
        #1;
        ptr_load  = 1'b0;
        cmd_valid = 1'b1;
        for (int i = 0; i < n; i++) begin
            cmd.code    = (i == n - 1) ? last : `CPW_CMD_WRITE_INC;
            cmd.payload = b[16*i +: 16];
            @(posedge core_clk);
            #1;
        end
        cmd_valid = 1'b0;
    endtask

    // run one externally timed pass; en of zero means no start expected
    task automatic run_prog(input logic [3:0] en, input logic multi, input logic [12:0] off);
        go = 1'b1;
        @(posedge core_clk);
        #1;
        go = 1'b0;
        // mid-way through the held fourth clock
        repeat (200) @(posedge core_clk);
        #1;
        check(prog.active, |en);
        check(prog.panel_en, en);
        if (|en) begin
            check(prog.multi, multi);
            check(prog.offset, off);
            // a store while programming is refused and leaves the buffers alone
            cmd_valid   = 1'b1;
            cmd.code    = `CPW_CMD_WRITE_INC;
            cmd.payload = 16'hffff;
            @(posedge core_clk);
            #1;
            cmd_valid = 1'b0;
        end
        for (int p = 0; p < 4; p++)
            if (en[p]) check(prog.data[p*64 +: 64], exp_data[p*64 +: 64]);
        for (int i = 0; i < 1000 && done !== 1'b1; i++)
            @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        #1;
        check(done, 1'b1);
        check(prog.active, 1'b0);
        check(prog.panel_en, 4'h0);
    endtask

    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        ptr_load = 1'b0;
        ptr_value = '0;
        go = 1'b0;
        code_space_select = 1'b1;
        config_space_select = 1'b1;
        write_enable_bit = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        check(programming_control, `CPW_PROG_CTRL_RST);
        check(table_pointer, 22'h00_0000);
        check(buffer_full, 4'h0);
        check(prog.active, 1'b0);
        load(`CPW_PROG_CTRL_ADDR, 64'h0000_0000_0000_0040, 1, `CPW_CMD_WRITE);
        check(programming_control, `CPW_MULTI_VALUE);
        config_space_select = 1'b0;
        fill(8'h00);
        for (int p = 0; p < 4; p++)
            load(22'(p) * `CPW_PANEL_SIZE + 22'h00_0010, exp_data[p*64 +: 64], 4,
                 (p == 3) ? `CPW_CMD_START : `CPW_CMD_WRITE);
        check(table_pointer, 22'h00_6016);
        check(buffer_full, 4'hf);
        check(prog.active, 1'b0);
        run_prog(4'hf, 1'b1, 13'h0010);
        check(buffer_full, 4'h0);
        // single panel pass at the next offset
        config_space_select = 1'b1;
        load(`CPW_PROG_CTRL_ADDR, 64'h0000_0000_0000_0000, 1, `CPW_CMD_WRITE);
        check(programming_control, 8'h00);
        config_space_select = 1'b0;
        fill(8'h5a);
        load(22'h00_4018, exp_data[128 +: 64], 4, `CPW_CMD_START);
        check(table_pointer, 22'h00_401e);
        run_prog(4'b0100, 1'b0, 13'h0018);
        // start without write enable must not program
        write_enable_bit = 1'b0;
        load(22'h00_0000, 64'h0123_4567_89ab_cdef, 4, `CPW_CMD_START);
        run_prog(4'h0, 1'b0, 13'h0000);
        check(buffer_full, 4'b0001);
        // a core command code is not a store
        load(22'h00_2000, 64'h0000_0000_0000_ffff, 1, `CPW_CMD_CORE);
        check(prog.data[64 +: 16], 16'h0908);
        // without code space access the stores are dropped
        code_space_select = 1'b0;
        write_enable_bit = 1'b1;
        load(22'h00_2000, 64'hffff_ffff_ffff_ffff, 4, `CPW_CMD_WRITE);
        check(buffer_full, 4'b0001);
        check(prog.data[64 +: 16], 16'h0908);
        final_report();
    end
endmodule // code_memory_panel_writer_bench
